// file: core/pco_beat_sum.sv
`timescale 1ns/1ps
`default_nettype none
`include "pco_defs.svh"
// Folds one 32-bit beat into a 16-bit ones' complement sum
module pco_beat_sum (
	input wire logic [`PCO_SW-1:0] acc_i,
	input wire logic [`PCO_DW-1:0] data_i,
	input wire logic [`PCO_KW-1:0] mask_i,
	output logic [`PCO_SW-1:0] sum_o
);
	// End-around carry add
	function automatic logic [`PCO_SW-1:0] add1c(
		input logic [`PCO_SW-1:0] a,
		input logic [`PCO_SW-1:0] b);
		logic [`PCO_SW:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[`PCO_SW-1:0] + {{(`PCO_SW-1){1'b0}}, s[`PCO_SW]};
	endfunction

	logic [`PCO_DW-1:0] word;
	logic [`PCO_SW-1:0] part;

	// Lane 0 is the earlier byte, so it lands in the high half
	genvar g;
	generate
		for (g = 0; g < `PCO_KW; g++) begin : g_lane
			localparam int HI = (g % 2 == 0) ? 1 : 0;
			localparam int PAIR = g / 2;
			assign word[PAIR*16+HI*8 +: 8] = mask_i[g] ? data_i[g*8 +: 8] : 8'h00;
		end
	endgenerate

	// Masked bytes are zero, which pads an odd final byte
	assign part = add1c(acc_i, word[`PCO_SW-1:0]);
	assign sum_o = add1c(part, word[`PCO_DW-1:`PCO_SW]);
endmodule // pco_beat_sum
`default_nettype wire

// file: core/pco_offload.sv
`timescale 1ns/1ps
`default_nettype none
`include "pco_defs.svh"
// Function
// - Transmit and receive frames use separate 32-bit streams to and from MAC.
// - Transmit parameters arrive on control stream; receive sums leave on status.
// - Transmit and receive sum logic each kept or dropped by build option.
// - Start offset is a zero-based byte index; summing begins there.
// - Control bit 0 set writes the sum in; otherwise frame unchanged.
// - A 16-bit per-frame seed is added into the transmit sum.
// - A computed transmit sum of zero is sent as all ones.
// - Receive raw sum runs from byte 14 to the last frame byte.
// - Receive FCS bytes delivered by the MAC are included in raw sum.
module pco_offload #(
	parameter bit tx_sum_offload_option = 1'b1,
	parameter bit rx_sum_offload_option = 1'b1
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic s_tx_tvalid_i,
	input wire pco_pkg::pco_axis_s s_tx_i,
	output logic s_tx_tready_o,
	input wire logic s_ctl_tvalid_i,
	input wire pco_pkg::pco_axis_s s_ctl_i,
	output logic s_ctl_tready_o,
	output logic m_tx_tvalid_o,
	output var pco_pkg::pco_axis_s m_tx_o,
	input wire logic m_tx_tready_i,
	input wire logic s_rx_tvalid_i,
	input wire pco_pkg::pco_axis_s s_rx_i,
	output logic s_rx_tready_o,
	output logic m_rx_tvalid_o,
	output var pco_pkg::pco_axis_s m_rx_o,
	input wire logic m_rx_tready_i,
	output logic m_sts_tvalid_o,
	output var pco_pkg::pco_axis_s m_sts_o,
	input wire logic m_sts_tready_i,
	input wire logic [`PCO_RAW-1:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [`PCO_DW-1:0] s_axil_wdata,
	input wire logic [`PCO_KW-1:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [`PCO_RAW-1:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [`PCO_DW-1:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready
);
	import pco_pkg::*;

	// Lanes of a beat that are in use and at or past the start byte
	function automatic logic [`PCO_KW-1:0] from_mask(
		input logic [`PCO_PW-1:0] pos,
		input logic [`PCO_PW-1:0] start,
		input logic [`PCO_KW-1:0] keep);
		logic [`PCO_KW-1:0] m;
		m = '0;
		for (int l = 0; l < `PCO_KW; l++) begin
			m[l] = keep[l] && ((pos + `PCO_PW'(l)) >= start);
		end
		return m;
	endfunction

	// ------------------------------------------------------------
	// Transmit: capture frame, sum it, then replay with the sum
	// ------------------------------------------------------------
	// The sum is known only at frame end, yet it sits in the header,
	// so the whole frame must be held before any of it goes out.
	logic [`PCO_DW+`PCO_KW-1:0] tx_mem [`PCO_DEPTH];
	pco_tx_e tx_st_q, tx_st_d;
	logic [`PCO_AW-1:0] wr_q, rd_q, cnt_q;
	logic [`PCO_PW-1:0] tx_pos_q, start_q, woff_q, seed_q;
	logic ins_q, ctl_beat_q, tx_in_rdy_q, ctl_rdy_q, ctrl_gate_q;
	logic [`PCO_SW-1:0] tx_acc_q, tx_acc_d, tx_sum_q;
	logic [`PCO_PW-1:0] tx_frames_q, rx_frames_q;
	logic m_tx_v_q;
	pco_axis_s m_tx_q;
	wire ctl_take = s_ctl_tvalid_i && ctl_rdy_q;
	wire tx_take = s_tx_tvalid_i && tx_in_rdy_q;
	// Seed as of this edge, so a one-beat control group is not a frame late
	wire [`PCO_SW-1:0] seed_now = (ctl_take && !ctl_beat_q)
		? s_ctl_i.data[`PCO_SW-1:0] : seed_q;
	wire tx_slot = !m_tx_v_q || m_tx_tready_i;
	wire tx_emit = (tx_st_q == PCO_TX_SEND) && tx_slot;
	wire tx_done = tx_emit && (rd_q == cnt_q);
	wire [`PCO_KW-1:0] tx_mask = from_mask(tx_pos_q, start_q, s_tx_i.keep);
	wire [`PCO_DW+`PCO_KW-1:0] tx_word = tx_mem[rd_q];
	wire [`PCO_SW-1:0] tx_cpl = ~tx_acc_d;
	wire [`PCO_SW-1:0] tx_fin = (tx_cpl == '0) ? `PCO_ALL_ONES : tx_cpl;
	wire tx_hit = ins_q && (`PCO_PW'(rd_q) == (woff_q >> 2));
	wire [1:0] lane = woff_q[1:0];
	logic [`PCO_DW-1:0] tx_out;

	generate
		if (tx_sum_offload_option) begin : g_txs
			pco_beat_sum u_txs (
				.acc_i(tx_acc_q),
				.data_i(s_tx_i.data),
				.mask_i(tx_mask),
				.sum_o(tx_acc_d)
			);
		end else begin : g_notxs
			assign tx_acc_d = '0;
		end
	endgenerate

	// Patch the two sum bytes, high byte first, into lane woff_q[1:0] and the lane above it
	always_comb begin
		tx_out = tx_word[`PCO_DW+`PCO_KW-1:`PCO_KW];
		if (tx_hit) begin
			tx_out[lane*8 +: 8] = tx_sum_q[15:8];
			tx_out[lane*8+8 +: 8] = tx_sum_q[7:0];
		end
	end

	// Sequence: control words, then frame intake, then replay
	always_comb begin
		tx_st_d = tx_st_q;
		case (tx_st_q)
			PCO_TX_CTRL: if (ctl_take && s_ctl_i.last) tx_st_d = PCO_TX_LOAD;
			PCO_TX_LOAD: if (tx_take && s_tx_i.last) tx_st_d = PCO_TX_SEND;
			PCO_TX_SEND: if (tx_done) tx_st_d = PCO_TX_CTRL;
			default: tx_st_d = PCO_TX_CTRL;
		endcase
	end

	// Control beat 0: {write control, seed}; beat 1: {write off, start off}
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ctl_beat_q <= 1'b0;
			ins_q <= 1'b0;
			seed_q <= '0;
			start_q <= '0;
			woff_q <= '0;
		end else if (ctl_take) begin
			ctl_beat_q <= !s_ctl_i.last;
			if (!ctl_beat_q) begin
				ins_q <= s_ctl_i.data[`PCO_SW+`PCO_INS_BIT] && ctrl_gate_q
					&& tx_sum_offload_option;
				seed_q <= s_ctl_i.data[`PCO_SW-1:0];
			end else begin
				woff_q <= s_ctl_i.data[`PCO_DW-1:`PCO_SW];
				start_q <= s_ctl_i.data[`PCO_SW-1:0];
			end
		end
	end

	// Frame intake: store beats, fold them into the seeded sum
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			wr_q <= '0;
			cnt_q <= '0;
			tx_pos_q <= '0;
			tx_acc_q <= '0;
			tx_sum_q <= '0;
		end else if (tx_st_q == PCO_TX_CTRL) begin
			wr_q <= '0;
			tx_pos_q <= '0;
			tx_acc_q <= seed_now;
		end else if (tx_take) begin
			// Over-long frames keep overwriting the last slot
			if (wr_q != `PCO_LAST_SLOT) wr_q <= wr_q + `PCO_ONE_SLOT;
			tx_pos_q <= tx_pos_q + `PCO_BEAT_BYTES;
			tx_acc_q <= tx_acc_d;
			if (s_tx_i.last) begin
				cnt_q <= wr_q;
				tx_sum_q <= tx_fin;
			end
		end
	end

	// Frame store write port
	always_ff @(posedge clk_i) begin
		if (tx_take) tx_mem[wr_q] <= {s_tx_i.data, s_tx_i.keep};
	end

	// Replay toward the MAC through an output register
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			tx_st_q <= PCO_TX_CTRL;
			ctl_rdy_q <= 1'b0;
			tx_in_rdy_q <= 1'b0;
			rd_q <= '0;
			m_tx_v_q <= 1'b0;
			m_tx_q <= '0;
			tx_frames_q <= '0;
		end else begin
			tx_st_q <= tx_st_d;
			ctl_rdy_q <= (tx_st_d == PCO_TX_CTRL) && !(ctl_take && s_ctl_i.last);
			tx_in_rdy_q <= (tx_st_d == PCO_TX_LOAD) && !(tx_take && s_tx_i.last);
			if (tx_st_q != PCO_TX_SEND) rd_q <= '0;
			else if (tx_emit) rd_q <= rd_q + `PCO_ONE_SLOT;
			if (tx_emit) begin
				m_tx_v_q <= 1'b1;
				m_tx_q <= '{data: tx_out, keep: tx_word[`PCO_KW-1:0],
					last: rd_q == cnt_q};
			end else if (m_tx_tready_i) begin
				m_tx_v_q <= 1'b0;
			end
			if (tx_done) tx_frames_q <= tx_frames_q + `PCO_CNT_ONE;
		end
	end

	// ------------------------------------------------------------
	// Receive: pass frames through, sum from byte 14 to the end
	// ------------------------------------------------------------
	// Intake only into an empty stage keeps ready a plain flop,
	// at the price of one beat every other cycle.
	logic rx_rdy_q, m_rx_v_q, sts_v_q;
	logic [`PCO_PW-1:0] rx_pos_q;
	logic [`PCO_SW-1:0] rx_acc_q, rx_acc_d, rx_last_q;
	pco_axis_s m_rx_q, sts_q;
	wire rx_take = s_rx_tvalid_i && rx_rdy_q;
	wire [`PCO_KW-1:0] rx_mask = from_mask(rx_pos_q, `PCO_RX_START,
		s_rx_i.keep);
	wire rx_v_d = rx_take || (m_rx_v_q && !m_rx_tready_i);
	wire sts_v_d = (rx_take && s_rx_i.last && rx_sum_offload_option)
		|| (sts_v_q && !m_sts_tready_i);

	generate
		if (rx_sum_offload_option) begin : g_rxs
			pco_beat_sum u_rxs (
				.acc_i(rx_acc_q),
				.data_i(s_rx_i.data),
				.mask_i(rx_mask),
				.sum_o(rx_acc_d)
			);
		end else begin : g_norxs
			assign rx_acc_d = '0;
		end
	endgenerate

	// Every delivered byte from byte 14 on counts, FCS too when the MAC keeps it
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rx_rdy_q <= 1'b0;
			m_rx_v_q <= 1'b0;
			m_rx_q <= '0;
			sts_v_q <= 1'b0;
			sts_q <= '0;
			rx_pos_q <= '0;
			rx_acc_q <= '0;
			rx_last_q <= '0;
			rx_frames_q <= '0;
		end else begin
			rx_rdy_q <= !rx_v_d && !sts_v_d;
			m_rx_v_q <= rx_v_d;
			sts_v_q <= sts_v_d;
			if (rx_take) begin
				m_rx_q <= s_rx_i;
				rx_pos_q <= s_rx_i.last ? '0 : rx_pos_q + `PCO_BEAT_BYTES;
				rx_acc_q <= s_rx_i.last ? '0 : rx_acc_d;
				if (s_rx_i.last) begin
					sts_q <= '{data: {{`PCO_SW{1'b0}}, rx_acc_d},
						keep: '1, last: 1'b1};
					rx_last_q <= rx_acc_d;
					rx_frames_q <= rx_frames_q + `PCO_CNT_ONE;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite slave: write and read, one of each at a time
	// ------------------------------------------------------------
	logic aw_rdy_q, w_rdy_q, b_v_q, ar_rdy_q, r_v_q;
	logic [1:0] b_resp_q, r_resp_q;
	logic [`PCO_DW-1:0] r_data_q, rd_mux;
	logic rd_ok;
	wire wr_go = s_axil_awvalid && s_axil_wvalid && !b_v_q && !aw_rdy_q;
	wire wr_hs = aw_rdy_q && w_rdy_q;
	wire rd_go = s_axil_arvalid && !r_v_q && !ar_rdy_q;
	wire wr_ctrl = s_axil_awaddr == `PCO_REG_CTRL;

	// Read decode; unmapped offsets answer SLVERR with zero data
	always_comb begin
		rd_mux = '0;
		rd_ok = 1'b1;
		if (s_axil_araddr == `PCO_REG_CTRL) rd_mux[0] = ctrl_gate_q;
		else if (s_axil_araddr == `PCO_REG_STAT) rd_mux = {rx_frames_q, tx_frames_q};
		else if (s_axil_araddr == `PCO_REG_RXSUM) rd_mux[`PCO_SW-1:0] = rx_last_q;
		else if (s_axil_araddr == `PCO_REG_OPT) rd_mux[1:0] = {rx_sum_offload_option,
			tx_sum_offload_option};
		else rd_ok = 1'b0;
	end

	// Address and data are taken together, answer follows next cycle
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			aw_rdy_q <= 1'b0;
			w_rdy_q <= 1'b0;
			b_v_q <= 1'b0;
			b_resp_q <= `PCO_RESP_OKAY;
			ar_rdy_q <= 1'b0;
			r_v_q <= 1'b0;
			r_resp_q <= `PCO_RESP_OKAY;
			r_data_q <= '0;
			ctrl_gate_q <= `PCO_CTRL_RST;
		end else begin
			aw_rdy_q <= wr_go;
			w_rdy_q <= wr_go;
			if (wr_hs) begin
				b_v_q <= 1'b1;
				b_resp_q <= wr_ctrl ? `PCO_RESP_OKAY : `PCO_RESP_SLVERR;
				if (wr_ctrl && s_axil_wstrb[0]) ctrl_gate_q <= s_axil_wdata[0];
			end else if (s_axil_bready) begin
				b_v_q <= 1'b0;
			end
			ar_rdy_q <= rd_go;
			if (ar_rdy_q) begin
				r_v_q <= 1'b1;
				r_data_q <= rd_mux;
				r_resp_q <= rd_ok ? `PCO_RESP_OKAY : `PCO_RESP_SLVERR;
			end else if (s_axil_rready) begin
				r_v_q <= 1'b0;
			end
		end
	end

	// Every port below is a flop
	assign s_tx_tready_o = tx_in_rdy_q;
	assign s_ctl_tready_o = ctl_rdy_q;
	assign m_tx_tvalid_o = m_tx_v_q;
	assign m_tx_o = m_tx_q;
	assign s_rx_tready_o = rx_rdy_q;
	assign m_rx_tvalid_o = m_rx_v_q;
	assign m_rx_o = m_rx_q;
	assign m_sts_tvalid_o = sts_v_q;
	assign m_sts_o = sts_q;
	assign s_axil_awready = aw_rdy_q;
	assign s_axil_wready = w_rdy_q;
	assign s_axil_bvalid = b_v_q;
	assign s_axil_bresp = b_resp_q;
	assign s_axil_arready = ar_rdy_q;
	assign s_axil_rvalid = r_v_q;
	assign s_axil_rresp = r_resp_q;
	assign s_axil_rdata = r_data_q;
endmodule // pco_offload
`default_nettype wire

// file: pkg/pco_defs.svh
`ifndef PCO_DEFS_SVH
`define PCO_DEFS_SVH
// ------------------------------------------------------------
// Widths and depths
// ------------------------------------------------------------
`define PCO_DW 32
`define PCO_KW 4
`define PCO_SW 16
`define PCO_PW 16
`define PCO_AW 9
`define PCO_DEPTH 512
`define PCO_LAST_SLOT 9'h1ff
`define PCO_BEAT_BYTES 16'h0004
`define PCO_ONE_SLOT 9'h001
`define PCO_CNT_ONE 16'h0001
// ------------------------------------------------------------
// Frame layout
// ------------------------------------------------------------
`define PCO_RX_START 16'h000e
`define PCO_ALL_ONES 16'hffff
`define PCO_INS_BIT 0
// ------------------------------------------------------------
// Register map (byte addresses, low nibble decoded)
// ------------------------------------------------------------
`define PCO_RAW 4
`define PCO_REG_CTRL 4'h0
`define PCO_REG_STAT 4'h4
`define PCO_REG_RXSUM 4'h8
`define PCO_REG_OPT 4'hc
`define PCO_CTRL_RST 1'b1
`define PCO_RESP_OKAY 2'b00
`define PCO_RESP_SLVERR 2'b10
`endif

// file: pkg/pco_pkg.sv
`include "pco_defs.svh"
package pco_pkg;
	// One stream beat: data, byte lanes in use, frame end
	typedef struct packed {
		logic [`PCO_DW-1:0] data;
		logic [`PCO_KW-1:0] keep;
		logic last;
	} pco_axis_s;

	// Transmit sequencing
	typedef enum logic [2:0] {
		PCO_TX_CTRL = 3'b001,
		PCO_TX_LOAD = 3'b010,
		PCO_TX_SEND = 3'b100
	} pco_tx_e;
endpackage

// file: test/pco_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side sinks: link toward the MAC and the DMA receive channels
module pco_far_model (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic slow_i,
	output logic tx_ready_o,
	output logic rx_ready_o,
	output logic sts_ready_o
);
	logic [1:0] cnt_q;
	// Phase counter; slow mode stalls so every held beat is exercised
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cnt_q <= 2'h0;
		end else begin
			cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
		end
	end
	assign tx_ready_o = !slow_i || cnt_q == 2'h0;
	assign rx_ready_o = !slow_i || cnt_q == 2'h1;
	assign sts_ready_o = !slow_i || cnt_q != 2'h0;
endmodule // pco_far_model
`default_nettype wire

// file: test/pco_offload_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Stream protocol watch on the offload top ports
module pco_offload_properties (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic s_ctl_tvalid_i,
	input wire pco_pkg::pco_axis_s s_ctl_i,
	input wire logic s_ctl_tready_o,
	input wire logic s_tx_tvalid_i,
	input wire pco_pkg::pco_axis_s s_tx_i,
	input wire logic s_tx_tready_o,
	input wire logic m_tx_tvalid_o,
	input wire pco_pkg::pco_axis_s m_tx_o,
	input wire logic m_tx_tready_i,
	input wire logic s_rx_tvalid_i,
	input wire pco_pkg::pco_axis_s s_rx_i,
	input wire logic s_rx_tready_o,
	input wire logic m_rx_tvalid_o,
	input wire pco_pkg::pco_axis_s m_rx_o,
	input wire logic m_sts_tvalid_o,
	input wire pco_pkg::pco_axis_s m_sts_o,
	input wire logic m_sts_tready_i
);
	import pco_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// --------------------------------------------------------
	// Handshake steps
	// --------------------------------------------------------
	sequence ctl_end_s;
		s_ctl_tvalid_i && s_ctl_tready_o && s_ctl_i.last;
	endsequence
	sequence tx_end_s;
		s_tx_tvalid_i && s_tx_tready_o && s_tx_i.last;
	endsequence
	sequence rx_take_s;
		s_rx_tvalid_i && s_rx_tready_o;
	endsequence
	sequence rx_end_s;
		s_rx_tvalid_i && s_rx_tready_o && s_rx_i.last;
	endsequence
	// --------------------------------------------------------
	// Checks
	// --------------------------------------------------------
	ctl_handoff_a: assert property (
		ctl_end_s |=> !s_ctl_tready_o && s_tx_tready_o)
		else $error("control end did not open frame intake");
	tx_launch_a: assert property (
		tx_end_s |=> !m_tx_tvalid_o ##1 m_tx_tvalid_o)
		else $error("stored frame not launched two cycles after its end");
	tx_hold_a: assert property (
		m_tx_tvalid_o && !m_tx_tready_i |=> m_tx_tvalid_o && $stable(m_tx_o))
		else $error("stalled transmit beat changed");
	tx_gate_a: assert property (
		s_tx_tready_o |-> !s_ctl_tready_o && !m_tx_tvalid_o)
		else $error("frame intake open while control or replay active");
	rx_pass_a: assert property (
		rx_take_s |=> m_rx_tvalid_o && m_rx_o == $past(s_rx_i))
		else $error("receive beat not forwarded intact");
	sts_follow_a: assert property (
		rx_end_s |=> m_sts_tvalid_o && m_sts_o.last && m_sts_o.keep == 4'hf)
		else $error("status beat missing after frame end");
	sts_hold_a: assert property (
		m_sts_tvalid_o && !m_sts_tready_i |=> m_sts_tvalid_o && $stable(m_sts_o))
		else $error("stalled status beat changed");
	rx_refuse_a: assert property (
		m_rx_tvalid_o || m_sts_tvalid_o |-> !s_rx_tready_o)
		else $error("receive intake open with full output stage");
endmodule // pco_offload_properties
bind pco_offload pco_offload_properties u_props (.clk_i(clk_i),
	.rstn_i(rstn_i), .s_ctl_tvalid_i(s_ctl_tvalid_i), .s_ctl_i(s_ctl_i),
	.s_ctl_tready_o(s_ctl_tready_o), .s_tx_tvalid_i(s_tx_tvalid_i),
	.s_tx_i(s_tx_i), .s_tx_tready_o(s_tx_tready_o),
	.m_tx_tvalid_o(m_tx_tvalid_o), .m_tx_o(m_tx_o),
	.m_tx_tready_i(m_tx_tready_i), .s_rx_tvalid_i(s_rx_tvalid_i),
	.s_rx_i(s_rx_i), .s_rx_tready_o(s_rx_tready_o),
	.m_rx_tvalid_o(m_rx_tvalid_o), .m_rx_o(m_rx_o),
	.m_sts_tvalid_o(m_sts_tvalid_o), .m_sts_o(m_sts_o),
	.m_sts_tready_i(m_sts_tready_i));
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pco_pkg::*;
	logic clk_i, rstn_i = 1'b0, slow = 1'b0;
	logic [2:0] vld = 3'h0;
	pco_axis_s beat = '0, m_tx_o, m_rx_o, m_sts_o;
	logic s_tx_tready_o, s_ctl_tready_o, s_rx_tready_o, m_tx_tvalid_o;
	logic m_rx_tvalid_o, m_sts_tvalid_o, tx_rdy, rx_rdy, sts_rdy;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid;
	logic arready, rvalid;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	logic [7:0] fr [68];
	logic [7:0] txq [$], rxq [$];
	logic [15:0] stsq [$];
	int num_errors = 0, compares = 0;
	wire [2:0] rdy = {s_ctl_tready_o, s_rx_tready_o, s_tx_tready_o};
	pco_offload u_dut (.clk_i(clk_i), .rstn_i(rstn_i),
		.s_tx_tvalid_i(vld[0]), .s_tx_i(beat), .s_tx_tready_o(s_tx_tready_o),
		.s_ctl_tvalid_i(vld[2]), .s_ctl_i(beat),
		.s_ctl_tready_o(s_ctl_tready_o), .m_tx_tvalid_o(m_tx_tvalid_o),
		.m_tx_o(m_tx_o), .m_tx_tready_i(tx_rdy), .s_rx_tvalid_i(vld[1]),
		.s_rx_i(beat), .s_rx_tready_o(s_rx_tready_o),
		.m_rx_tvalid_o(m_rx_tvalid_o), .m_rx_o(m_rx_o),
		.m_rx_tready_i(rx_rdy), .m_sts_tvalid_o(m_sts_tvalid_o),
		.m_sts_o(m_sts_o), .m_sts_tready_i(sts_rdy),
		.s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
		.s_axil_awready(awready), .s_axil_wdata(wdata),
		.s_axil_wstrb(4'hf), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
		.s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
		.s_axil_bready(bready), .s_axil_araddr(araddr),
		.s_axil_arvalid(arvalid), .s_axil_arready(arready),
		.s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
		.s_axil_rready(rready));
	pco_far_model u_far (.clk_i(clk_i), .rstn_i(rstn_i), .slow_i(slow),
		.tx_ready_o(tx_rdy), .rx_ready_o(rx_rdy), .sts_ready_o(sts_rdy));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// Output collectors: data byte by byte in stream order, status as one 16-bit sum per beat
	always @(posedge clk_i) begin
		for (int k = 0; k < 4; k++) begin
			if (m_tx_tvalid_o && tx_rdy && m_tx_o.keep[k])
				txq.push_back(m_tx_o.data[8*k +: 8]);
			if (m_rx_tvalid_o && rx_rdy && m_rx_o.keep[k])
				rxq.push_back(m_rx_o.data[8*k +: 8]);
		end
		if (m_sts_tvalid_o && sts_rdy)
			stsq.push_back(m_sts_o.data[15:0]);
	end
	task automatic finish_test();
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tmo(input int t, input int lim);
		if (t >= lim) begin
			check("wait bound", t, 0);
			finish_test();
		end
	endtask
	// Ones' complement sum of big-endian pairs, odd tail padded with zero
	function automatic logic [15:0] csum(input int from, input int n,
		input logic [15:0] seed);
		logic [31:0] s;
		s = {16'h0, seed};
		for (int i = from; i < n; i += 2)
			s += {16'h0, fr[i], (i + 1 < n) ? fr[i+1] : 8'h00};
		while (s[31:16] != 16'h0)
			s = s[15:0] + s[31:16];
		return s[15:0];
	endfunction
	task automatic fill(input int k, input int wr);
		for (int i = 0; i < 68; i++)
			fr[i] = 8'(i * k + 3);
		fr[wr] = 8'h00;
		fr[wr+1] = 8'h00;
	endtask
	// One beat on the stream chosen by sel, held until taken
	task automatic put(input int sel, input pco_axis_s b);
		int t;
		t = 0;
		beat <= b;
		vld <= 3'b001 << sel;
		do begin
			@(posedge clk_i);
			t++;
		end while (rdy[sel] !== 1'b1 && t < 300);
		tmo(t, 300);
	endtask
	task automatic send(input int sel, input int n);
		pco_axis_s b;
		for (int i = 0; i < n; i += 4) begin
			b.data = {fr[i+3], fr[i+2], fr[i+1], fr[i]};
			b.keep = 4'hf >> ((i + 4 > n) ? i + 4 - n : 0);
			b.last = i + 4 >= n;
			put(sel, b);
		end
		vld <= 3'h0;
	endtask
	task automatic axi(input bit wr, input logic [3:0] a,
		input logic [31:0] d, input logic [1:0] er);
		int t;
		t = 0;
		awaddr <= a;
		araddr <= a;
		wdata <= d;
		awvalid <= wr;
		wvalid <= wr;
		bready <= wr;
		arvalid <= !wr;
		rready <= !wr;
		do begin
			@(posedge clk_i);
			t++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (arready)
				arvalid <= 1'b0;
		end while ((wr ? bvalid : rvalid) !== 1'b1 && t < 50);
		bready <= 1'b0;
		rready <= 1'b0;
		tmo(t, 50);
		check("resp", wr ? bresp : rresp, er);
		if (!wr)
			check("rdata", rdata, d);
		// Let an edge pass so a following call never reassigns in this step
		@(posedge clk_i);
	endtask
	task automatic tx_case(input int n, input int st, input int wr,
		input logic [15:0] c, input logic [15:0] sd);
		logic [15:0] s;
		logic [7:0] e;
		int t;
		s = ~csum(st, n, sd);
		if (s == 16'h0)
			s = 16'hffff;
		put(2, '{{c, sd}, 4'hf, 1'b0});
		put(2, '{{16'(wr), 16'(st)}, 4'hf, 1'b1});
		send(0, n);
		for (t = 0; t < 2000 && txq.size() < n; t++)
			@(posedge clk_i);
		tmo(t, 2000);
		for (int i = 0; i < n; i++) begin
			e = (c[0] && i == wr) ? s[15:8] : (c[0] && i == wr + 1) ? s[7:0] : fr[i];
			check("tx byte", txq[i], e);
		end
		txq.delete();
		$display("tx case done");
	endtask
	task automatic rx_case(input int n);
		int t;
		send(1, n);
		// Status may be taken before the last data beat in slow mode
		for (t = 0; t < 2000 && (stsq.size() < 1 || rxq.size() < n); t++)
			@(posedge clk_i);
		tmo(t, 2000);
		check("rx len", rxq.size(), n);
		for (int i = 0; i < n; i++)
			check("rx byte", rxq[i], fr[i]);
		check("raw sum", stsq[0], csum(14, n, 16'h0));
		axi(1'b0, 4'h8, {16'h0, csum(14, n, 16'h0)}, 2'b00);
		rxq.delete();
		stsq.delete();
		$display("rx case done");
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		axi(1'b0, 4'hc, 32'h3, 2'b00);
		axi(1'b0, 4'h0, 32'h1, 2'b00);
		axi(1'b1, 4'h0, 32'h0, 2'b00);
		axi(1'b0, 4'h0, 32'h0, 2'b00);
		axi(1'b1, 4'h0, 32'h1, 2'b00);
		axi(1'b0, 4'h2, 32'h0, 2'b10);
		axi(1'b1, 4'h6, 32'h5, 2'b10);
		$display("register test done");
		fill(37, 20);
		tx_case(31, 16, 20, 16'h0001, 16'h1234);
		fill(11, 16);
		slow <= 1'b1;
		tx_case(20, 14, 16, 16'h0000, 16'h00ff);
		fill(5, 22);
		tx_case(40, 14, 22, 16'h0001, ~csum(14, 40, 16'h0));
		fill(13, 66);
		rx_case(47);
		slow <= 1'b0;
		fill(29, 66);
		rx_case(60);
		axi(1'b0, 4'h4, 32'h0002_0003, 2'b00);
		finish_test();
	end
endmodule // tb
`default_nettype wire
